// ==== hdl/ir_timer_control.sv ====
/*
 Byte and word infrared timers with shared control, AXI4-Lite register slave.
 Assumes demodulation pins are asynchronous; port value inputs come from aclk logic.
*/
// Functional notes
// - Byte timer enable bit written 1 starts counting, written 0 stops it.
// - Byte oneshot bit 0 reloads at transmit terminal count, 1 stops there.
// - Byte terminal flag sets at terminal count, cleared only by writing 1.
// - Byte capture and timeout interrupt enables gate their events.
// - Byte route bit selects port value or byte timer output on its pin.
// - Shared bit 7 selects transmit (0) or demodulation (1); resets 0.
// - Shared bit 6 routes combined pin, or picks demod input pin a or b.
// - Captures from demod input pin a also raise external interrupt two.
// - Transmit bits 5:4 combine outputs: AND, OR, NOR, NAND; reset 00.
// - Demod bits 5:4 select falling, rising or both edges; 11 reserved.
// - Transmit bits 3:2: 00 or 01 normal, 10 or 11 force word output 0 or 1.
// - Demod bits 3:2 filter glitches under 4 or 8 clocks; 11 reserved.
// - Shared bit 1 is byte output start level; opposite while disabled.
// - Demod shared bit 1 flags rising edges, cleared by writing 1.
// - Shared bit 0 is word output start level unless output forced.
// - Demod shared bit 0 flags falling edges, cleared by writing 1.
// - Word enable bit 7 starts or stops word timer, reads current state.
// - Word bit 6: reload or stop; demod capture every edge or first only.
// - Word terminal flag bit 5 sets at terminal count, cleared by writing 1.
// - Word bits 4:3 pick count clock: full, half, quarter, eighth rate.
// - Word bits 2 and 1 enable capture and timeout interrupts.
`timescale 1ns/100ps
module ir_timer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ir_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ir_timer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic demod_in_pin_a,
    input wire logic demod_in_pin_b,
    input wire logic byte_pin_port_val,
    input wire logic word_pin_port_val,
    input wire logic combined_pin_port_val,
    output logic byte_timer_pin,
    output logic word_timer_pin,
    output logic combined_out_pin,
    output logic byte_timer_irq,
    output logic word_timer_irq,
    output logic ext_irq_two
);
    import ir_timer_pkg::*;

    // ----------------------------------------
    // Register bus decode
    // ----------------------------------------
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] rd_val;
    logic wr_fire, wr_hit, rd_fire, rd_map;
    logic [3:0] wr_idx, rd_idx;
    logic [7:0] wdat;
    logic wr_b_ctrl, wr_sh, wr_w_ctrl;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[ADDR_W-1:6] == '0) && (a[5:2] <= IDX_BYTE_CAP_HI)
                 && (a[5:2] != 4'h3) && (a[1:0] == 2'h0);
    endfunction

    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign wr_idx = s_axi_awaddr[5:2];
    assign wr_hit = wr_fire && s_axi_wstrb[0] && mapped(s_axi_awaddr);
    assign wdat = s_axi_wdata[7:0];
    assign wr_b_ctrl = wr_hit && (wr_idx == IDX_BYTE_CTRL);
    assign wr_sh = wr_hit && (wr_idx == IDX_SHARED_CTRL);
    assign wr_w_ctrl = wr_hit && (wr_idx == IDX_WORD_CTRL);
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_map = mapped(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= {24'h0, rd_map ? rd_val : 8'h00};
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ----------------------------------------
    // Control and data registers
    // ----------------------------------------
    logic [7:0] sh_q, bc_q, wc_q;
    logic [7:0] b_hold_lo_q, b_hold_hi_q, w_hold_lo_q, w_hold_hi_q;
    logic [7:0] b_cap_lo_q, b_cap_hi_q;
    logic [15:0] w_cap_q;
    logic b_en_q, b_tc_q, w_en_q, w_tc_q;
    logic demod, rise_det, fall_det, b_term, w_term;

    assign demod = sh_q[SH_MODE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q <= CTRL_RESET;
        end else begin
            if (wr_sh) begin
                sh_q[7:2] <= wdat[7:2];
            end
            if (demod) begin
                sh_q[SH_INIT8] <= rise_det | (sh_q[SH_INIT8] & ~(wr_sh & wdat[SH_INIT8]));
                sh_q[SH_INIT16] <= fall_det
                    | (sh_q[SH_INIT16] & ~(wr_sh & wdat[SH_INIT16]));
            end else if (wr_sh) begin
                sh_q[1:0] <= wdat[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_q <= CTRL_RESET;
            wc_q <= CTRL_RESET;
            b_hold_lo_q <= 8'h00;
            b_hold_hi_q <= 8'h00;
            w_hold_lo_q <= 8'h00;
            w_hold_hi_q <= 8'h00;
        end else if (wr_hit) begin
            case (wr_idx)
                IDX_BYTE_CTRL: bc_q <= wdat;
                IDX_WORD_CTRL: wc_q <= wdat;
                IDX_BYTE_HOLD_LO: b_hold_lo_q <= wdat;
                IDX_BYTE_HOLD_HI: b_hold_hi_q <= wdat;
                IDX_WORD_HOLD_LO: w_hold_lo_q <= wdat;
                IDX_WORD_HOLD_HI: w_hold_hi_q <= wdat;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (rd_idx)
            IDX_BYTE_CTRL: rd_val = {b_en_q, bc_q[6], b_tc_q, bc_q[4:0]};
            IDX_SHARED_CTRL: rd_val = sh_q;
            IDX_WORD_CTRL: rd_val = {w_en_q, wc_q[6], w_tc_q, wc_q[4:0]};
            IDX_BYTE_HOLD_LO: rd_val = b_hold_lo_q;
            IDX_BYTE_HOLD_HI: rd_val = b_hold_hi_q;
            IDX_WORD_HOLD_LO: rd_val = w_hold_lo_q;
            IDX_WORD_HOLD_HI: rd_val = w_hold_hi_q;
            IDX_WORD_CAP_LO: rd_val = w_cap_q[7:0];
            IDX_WORD_CAP_HI: rd_val = w_cap_q[15:8];
            IDX_BYTE_CAP_LO: rd_val = b_cap_lo_q;
            IDX_BYTE_CAP_HI: rd_val = b_cap_hi_q;
            default: rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Input synchroniser, glitch filter, edges
    // ----------------------------------------
    logic a_s1_q, a_s2_q, b_s1_q, b_s2_q, raw, filt_q, filt_prev_q;
    logic [3:0] fcnt_q, flen;
    logic [1:0] esel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
        end else begin
            a_s1_q <= demod_in_pin_a;
            a_s2_q <= a_s1_q;
            b_s1_q <= demod_in_pin_b;
            b_s2_q <= b_s1_q;
        end
    end

    assign raw = sh_q[SH_ROUTE] ? b_s2_q : a_s2_q;
    assign flen = (sh_q[3:2] == FILT_SHORT) ? FILT_SHORT_CYC :
                  (sh_q[3:2] == FILT_LONG) ? FILT_LONG_CYC : FILT_NONE_CYC;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_q <= 1'b0;
            filt_prev_q <= 1'b0;
            fcnt_q <= 4'h0;
        end else begin
            filt_prev_q <= filt_q;
            if (raw == filt_q) begin
                fcnt_q <= 4'h0;
            end else if (fcnt_q + 4'h1 >= flen) begin
                filt_q <= raw;
                fcnt_q <= 4'h0;
            end else begin
                fcnt_q <= fcnt_q + 4'h1;
            end
        end
    end

    assign esel = sh_q[SH_LOGIC_HI:SH_LOGIC_LO];
    assign rise_det = demod && filt_q && !filt_prev_q
                      && (esel == EDGE_RISE || esel == EDGE_BOTH);
    assign fall_det = demod && !filt_q && filt_prev_q
                      && (esel == EDGE_FALL || esel == EDGE_BOTH);

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    logic [2:0] pre_q;
    logic b_tick, w_tick;

    function automatic logic tick_of(input logic [1:0] sel, input logic [2:0] p);
        case (sel)
            2'h0: tick_of = 1'b1;
            2'h1: tick_of = p[0];
            2'h2: tick_of = &p[1:0];
            default: tick_of = &p;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    assign b_tick = tick_of(bc_q[BIT_CLK_HI:BIT_CLK_LO], pre_q);
    assign w_tick = tick_of(wc_q[BIT_CLK_HI:BIT_CLK_LO], pre_q);

    // ----------------------------------------
    // Byte timer
    // ----------------------------------------
    demod_state_e b_dm_q;
    logic [7:0] b_cnt_q;
    logic b_out_q, b_start, b_edge, b_cap, byte_timer_out;

    assign b_start = wr_b_ctrl && wdat[BIT_EN] && !b_en_q;
    assign b_edge = b_en_q && (rise_det || fall_det);
    assign b_cap = b_edge && (b_dm_q == DM_RUN);
    assign b_term = b_en_q && !wr_b_ctrl && b_tick && (b_cnt_q == 8'h00) && !b_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_en_q <= 1'b0;
            b_cnt_q <= 8'h00;
            b_out_q <= 1'b0;
            b_dm_q <= DM_WAIT;
        end else if (wr_b_ctrl) begin
            b_en_q <= wdat[BIT_EN];
            if (b_start) begin
                b_out_q <= sh_q[SH_INIT8];
                b_cnt_q <= demod ? BYTE_FULL :
                           (sh_q[SH_INIT8] ? b_hold_hi_q : b_hold_lo_q);
                b_dm_q <= DM_WAIT;
            end
        end else if (b_en_q && demod) begin
            if (b_edge) begin
                b_dm_q <= DM_RUN;
                b_cnt_q <= BYTE_FULL;
            end else if (b_tick && b_dm_q == DM_RUN) begin
                b_cnt_q <= b_cnt_q - 8'h01;
            end
        end else if (b_term) begin
            b_out_q <= !b_out_q;
            b_cnt_q <= b_out_q ? b_hold_lo_q : b_hold_hi_q;
            if (bc_q[BIT_ONESHOT]) begin
                b_en_q <= 1'b0;
            end
        end else if (b_en_q && b_tick) begin
            b_cnt_q <= b_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_tc_q <= 1'b0;
            b_cap_lo_q <= 8'h00;
            b_cap_hi_q <= 8'h00;
        end else begin
            b_tc_q <= b_term | (b_tc_q & ~(wr_b_ctrl & wdat[BIT_TC]));
            if (b_cap && rise_det) begin
                b_cap_lo_q <= ~b_cnt_q;
            end else if (b_cap) begin
                b_cap_hi_q <= ~b_cnt_q;
            end
        end
    end

    assign byte_timer_out = b_en_q ? b_out_q : !sh_q[SH_INIT8];

    // ----------------------------------------
    // Word timer
    // ----------------------------------------
    logic [15:0] w_cnt_q;
    logic w_out_q, w_arm_q, w_start, w_edge, w_cap, w_lone, word_timer_out;
    logic [1:0] wsub;

    assign wsub = sh_q[SH_SUB_HI:SH_SUB_LO];
    assign w_start = wr_w_ctrl && wdat[BIT_EN] && !w_en_q;
    assign w_edge = w_en_q && demod && (rise_det || fall_det)
                    && (!wc_q[BIT_ONESHOT] || w_arm_q);
    assign w_lone = w_en_q && demod && wc_q[BIT_ONESHOT] && b_term;
    assign w_cap = w_edge || w_lone;
    assign w_term = w_en_q && !wr_w_ctrl && w_tick && (w_cnt_q == 16'h0000) && !w_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_en_q <= 1'b0;
            w_cnt_q <= 16'h0000;
            w_out_q <= 1'b0;
            w_arm_q <= 1'b1;
        end else if (wr_w_ctrl) begin
            w_en_q <= wdat[BIT_EN];
            if (wdat[BIT_ONESHOT] && (!wc_q[BIT_ONESHOT] || w_start)) begin
                w_arm_q <= 1'b1;
            end
            if (w_start) begin
                w_out_q <= sh_q[SH_INIT16];
                w_cnt_q <= demod ? WORD_FULL : {w_hold_hi_q, w_hold_lo_q};
            end
        end else if (w_edge) begin
            w_cnt_q <= WORD_FULL;
            w_arm_q <= 1'b0;
        end else if (w_term && !demod) begin
            w_out_q <= !w_out_q;
            w_cnt_q <= {w_hold_hi_q, w_hold_lo_q};
            if (wc_q[BIT_ONESHOT]) begin
                w_en_q <= 1'b0;
            end
        end else if (w_en_q && w_tick) begin
            w_cnt_q <= w_cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_tc_q <= 1'b0;
            w_cap_q <= 16'h0000;
        end else begin
            w_tc_q <= w_term | (w_tc_q & ~(wr_w_ctrl & wdat[BIT_TC]));
            if (w_cap) begin
                w_cap_q <= ~w_cnt_q;
            end
        end
    end

    always_comb begin
        if (!demod && wsub == SUB_FORCE0) begin
            word_timer_out = 1'b0;
        end else if (!demod && wsub == SUB_FORCE1) begin
            word_timer_out = 1'b1;
        end else begin
            word_timer_out = w_en_q ? w_out_q : !sh_q[SH_INIT16];
        end
    end

    // ----------------------------------------
    // Output combining, pins, interrupt requests
    // ----------------------------------------
    logic comb;

    always_comb begin
        case (esel)
            LOGIC_AND: comb = byte_timer_out & word_timer_out;
            LOGIC_OR: comb = byte_timer_out | word_timer_out;
            LOGIC_NOR: comb = ~(byte_timer_out | word_timer_out);
            default: comb = ~(byte_timer_out & word_timer_out);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_timer_pin <= 1'b0;
            word_timer_pin <= 1'b0;
            combined_out_pin <= 1'b0;
            byte_timer_irq <= 1'b0;
            word_timer_irq <= 1'b0;
            ext_irq_two <= 1'b0;
        end else begin
            byte_timer_pin <= bc_q[BIT_ROUTE] ? byte_timer_out : byte_pin_port_val;
            word_timer_pin <= wc_q[BIT_ROUTE] ? word_timer_out : word_pin_port_val;
            combined_out_pin <= (!demod && sh_q[SH_ROUTE]) ? comb : combined_pin_port_val;
            byte_timer_irq <= (b_term & bc_q[BIT_TO_IE]) | (b_cap & bc_q[BIT_CAP_IE]);
            word_timer_irq <= (w_term & wc_q[BIT_TO_IE]) | (w_cap & wc_q[BIT_CAP_IE]);
            ext_irq_two <= demod && !sh_q[SH_ROUTE] && (b_cap || w_cap);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_start;
        wr_b_ctrl |=> b_en_q == $past(wdat[BIT_EN]);
    endproperty
    a_b_start: assert property (p_b_start) else $error("byte timer not started");
    property p_b_oneshot;
        b_term && !demod && bc_q[BIT_ONESHOT] |=> !b_en_q && (b_out_q != $past(b_out_q));
    endproperty
    a_b_oneshot: assert property (p_b_oneshot) else $error("single pass did not stop");
    property p_b_tc;
        b_term |=> b_tc_q;
    endproperty
    a_b_tc: assert property (p_b_tc) else $error("byte flag not set");
    property p_b_tc_hold;
        b_tc_q && !(wr_b_ctrl && wdat[BIT_TC]) |=> b_tc_q;
    endproperty
    a_b_tc_hold: assert property (p_b_tc_hold) else $error("byte flag lost");
    property p_comb;
        !demod && sh_q[SH_ROUTE] && esel == LOGIC_AND |=>
            combined_out_pin == ($past(byte_timer_out) & $past(word_timer_out));
    endproperty
    a_comb: assert property (p_comb) else $error("combined pin wrong");
    property p_force;
        !demod && wsub == SUB_FORCE0 |-> !word_timer_out;
    endproperty
    a_force: assert property (p_force) else $error("word output not forced");
    property p_idle8;
        !b_en_q && bc_q[BIT_ROUTE] |=> byte_timer_pin != $past(sh_q[SH_INIT8]);
    endproperty
    a_idle8: assert property (p_idle8) else $error("idle byte level wrong");
    property p_rise_flag;
        rise_det |=> sh_q[SH_INIT8];
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("rising flag not set");
    property p_w_en;
        wr_w_ctrl |=> w_en_q == $past(wdat[BIT_EN]);
    endproperty
    a_w_en: assert property (p_w_en) else $error("word enable wrong");
    property p_w_tc;
        w_term |=> w_tc_q [*2] or (w_tc_q ##1 $past(wr_w_ctrl));
    endproperty
    a_w_tc: assert property (p_w_tc) else $error("word flag not held");
    c_b_term: cover property (b_term && b_en_q);
    c_w_cap: cover property (w_cap);
    c_fall: cover property (fall_det ##1 wr_sh);
endmodule // ir_timer_control

// ==== pkg/ir_timer_pkg.sv ====
/*
 Register indices, field positions and encodings for the infrared timer control block.
 Assumes a 32-bit AXI4-Lite master; byte address is four times the index.
*/
package ir_timer_pkg;
    localparam int ADDR_W = 8;
    // Register indices
    localparam logic [3:0] IDX_BYTE_CTRL = 4'h0;
    localparam logic [3:0] IDX_SHARED_CTRL = 4'h1;
    localparam logic [3:0] IDX_WORD_CTRL = 4'h2;
    localparam logic [3:0] IDX_BYTE_HOLD_LO = 4'h4;
    localparam logic [3:0] IDX_BYTE_HOLD_HI = 4'h5;
    localparam logic [3:0] IDX_WORD_HOLD_LO = 4'h6;
    localparam logic [3:0] IDX_WORD_HOLD_HI = 4'h7;
    localparam logic [3:0] IDX_WORD_CAP_LO = 4'h8;
    localparam logic [3:0] IDX_WORD_CAP_HI = 4'h9;
    localparam logic [3:0] IDX_BYTE_CAP_LO = 4'hA;
    localparam logic [3:0] IDX_BYTE_CAP_HI = 4'hB;
    // Timer control fields
    localparam int BIT_EN = 7;
    localparam int BIT_ONESHOT = 6;
    localparam int BIT_TC = 5;
    localparam int BIT_CLK_HI = 4;
    localparam int BIT_CLK_LO = 3;
    localparam int BIT_CAP_IE = 2;
    localparam int BIT_TO_IE = 1;
    localparam int BIT_ROUTE = 0;
    // Shared control fields
    localparam int SH_MODE = 7;
    localparam int SH_ROUTE = 6;
    localparam int SH_LOGIC_HI = 5;
    localparam int SH_LOGIC_LO = 4;
    localparam int SH_SUB_HI = 3;
    localparam int SH_SUB_LO = 2;
    localparam int SH_INIT8 = 1;
    localparam int SH_INIT16 = 0;
    // Encodings
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] SUB_FORCE0 = 2'h2;
    localparam logic [1:0] SUB_FORCE1 = 2'h3;
    localparam logic [1:0] FILT_SHORT = 2'h1;
    localparam logic [1:0] FILT_LONG = 2'h2;
    localparam logic [3:0] FILT_SHORT_CYC = 4'h4;
    localparam logic [3:0] FILT_LONG_CYC = 4'h8;
    localparam logic [3:0] FILT_NONE_CYC = 4'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_FULL = 8'hFF;
    localparam logic [15:0] WORD_FULL = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {DM_WAIT = 2'b01, DM_RUN = 2'b10} demod_state_e;
endpackage

// ==== verif/ir_pin_model.sv ====
/*
 Infrared input pin model: drives both demodulation input pins.
 Assumes the bench sets level and pin choice just after a clock edge.
*/
`timescale 1ns/100ps
module ir_pin_model (
    input wire logic sel_b,
    input wire logic lvl,
    output logic demod_in_pin_a,
    output logic demod_in_pin_b
);
    // Unselected pin rests at its pull-down level
    assign demod_in_pin_a = sel_b ? 1'h0 : lvl;
    assign demod_in_pin_b = sel_b ? lvl : 1'h0;
endmodule // ir_pin_model

// ==== verif/ir_timer_control_tb_top.sv ====
/*
 Self-checking bench: AXI4-Lite master tasks, pin model, expected values.
 Assumes the block answers every bus request; a cycle ceiling cuts hangs.
*/
`timescale 1ns/100ps
module ir_timer_control_tb_top;
    import ir_timer_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000, rdata, rs = 32'h26B3469C;
    logic [1:0] bresp, rresp;
    logic awr, wrdy, bv, arr, rv, pa, pb, bpin, wpin, cpin, birq, wirq, xirq, eb, ew;
    logic pvb = 1'h0, pvw = 1'h0, pvc = 1'h0, selb = 1'h0, lvl = 1'h0;
    int error_cnt = 0, checks = 0, cyc = 0, nx = 0, n, t0, op, ini, sub;
    // ----
    // Design and pins
    // ----
    ir_timer_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .demod_in_pin_a(pa), .demod_in_pin_b(pb), .byte_pin_port_val(pvb),
        .word_pin_port_val(pvw), .combined_pin_port_val(pvc), .byte_timer_pin(bpin),
        .word_timer_pin(wpin), .combined_out_pin(cpin), .byte_timer_irq(birq),
        .word_timer_irq(wirq), .ext_irq_two(xirq));
    ir_pin_model u_pins (.sel_b(selb), .lvl(lvl), .demod_in_pin_a(pa),
        .demod_in_pin_b(pb));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end
    always @(posedge aclk) begin
        if (xirq === 1'h1) nx++;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic cmb(input int o, input logic a, input logic b);
        return o == 0 ? a & b : o == 1 ? a | b : o == 2 ? ~(a | b) : ~(a & b);
    endfunction
    task automatic test_done;
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do @(posedge aclk); while (awr !== 1'h1);
        awv <= 1'h0;
        wv <= 1'h0;
        while (bv !== 1'h1) @(posedge aclk);
        chk("bresp", 32'(bresp), 32'(RESP_OKAY));
        br <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        do @(posedge aclk); while (arr !== 1'h1);
        arv <= 1'h0;
        while (rv !== 1'h1) @(posedge aclk);
        chk("rresp", 32'(rresp), 32'(er));
        chk("rdata", rdata, ed);
        rr <= 1'h0;
    endtask
    task automatic wt(input logic w);
        n = 0;
        while ((w ? wirq : birq) !== 1'h1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic pulse(input int w);
        @(posedge aclk);
        lvl <= 1'h1;
        repeat (w) @(posedge aclk);
        lvl <= 1'h0;
        repeat (20) @(posedge aclk);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00, 32'h00, RESP_OKAY);
        rd(8'h04, 32'h00, RESP_OKAY);
        rd(8'h08, 32'h00, RESP_OKAY);
        rd(8'h0C, 32'h00, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            rs = xs(rs);
            {pvb, pvw, pvc} <= rs[2:0];
            repeat (3) @(posedge aclk);
            chk("port_pins", 32'({bpin, wpin, cpin}), 32'(rs[2:0]));
        end
        wr(8'h00, 8'h01);
        wr(8'h08, 8'h01);
        for (int i = 0; i < 48; i++) begin
            op = i % 4;
            ini = (i / 4) % 4;
            sub = (i < 16) ? 0 : i / 16 + 1;
            wr(8'h04, 8'(32'h40 | op << 4 | sub << 2 | ini));
            eb = !ini[1];
            ew = sub == 2 ? 1'h0 : sub == 3 ? 1'h1 : !ini[0];
            repeat (3) @(posedge aclk);
            chk("pins", 32'({bpin, wpin, cpin}), 32'({eb, ew, cmb(op, eb, ew)}));
        end
        wr(8'h18, 8'h08);
        wr(8'h1C, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, 8'(32'hC2 | k << 3));
            wt(1'h1);
            chk("word_irq", 32'(n < 400), 32'h1);
            if (k > 0) chk("word_rate", 32'(n > t0), 32'h1);
            t0 = n;
            repeat (4) @(posedge aclk);
            rd(8'h08, 32'h62 | k << 3, RESP_OKAY);
            wr(8'h08, 8'(32'h42 | k << 3));
            rd(8'h08, 32'h62 | k << 3, RESP_OKAY);
            wr(8'h08, 8'h20);
            rd(8'h08, 32'h00, RESP_OKAY);
        end
        wr(8'h10, 8'h05);
        wr(8'h14, 8'h05);
        wr(8'h00, 8'h82);
        wt(1'h0);
        repeat (2) @(posedge aclk);
        wt(1'h0);
        chk("byte_reload", 32'(n < 400), 32'h1);
        wr(8'h00, 8'h02);
        rd(8'h00, 32'h22, RESP_OKAY);
        wr(8'h00, 8'h22);
        rd(8'h00, 32'h02, RESP_OKAY);
        wr(8'h04, 8'h80);
        for (int e = 0; e < 3; e++) begin
            wr(8'h04, 8'(32'h83 | e << 4));
            pulse(20);
            rd(8'h04, (32'h80 | e << 4) | (e == 0 ? 1 : e == 1 ? 2 : 3), RESP_OKAY);
        end
        wr(8'h04, 8'hAB);
        pulse(3);
        rd(8'h04, 32'hA8, RESP_OKAY);
        pulse(20);
        rd(8'h04, 32'hAB, RESP_OKAY);
        wr(8'h04, 8'hA2);
        rd(8'h04, 32'hA1, RESP_OKAY);
        wr(8'h08, 8'h84);
        pulse(20);
        rd(8'h04, 32'hA3, RESP_OKAY);
        chk("ext_irq", 32'(nx), 32'h2);
        wr(8'h04, 8'hE3);
        selb <= 1'h1;
        pulse(20);
        rd(8'h04, 32'hE3, RESP_OKAY);
        chk("ext_irq", 32'(nx), 32'h2);
        test_done();
    end
endmodule // ir_timer_control_tb_top
